// [core/ubr_baud_ctrl.sv]
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module ubr_baud_ctrl
    import ubr_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wr_data,
    input  wire logic        wr_en,
    input  wire logic        rd_en,
    output logic [31:0]      rd_data,
    input  wire logic        sck_in,
    output logic             sck_out,
    output logic             sck_oe,
    input  wire logic        rx_busy,
    input  wire logic        tx_busy,
    input  wire logic        holding_full,
    output logic             sample_tick,
    output logic             baud_tick,
    output logic             rx_enable,
    output logic             tx_enable,
    output logic             rx_reset,
    output logic             tx_reset
);
    ubr_mode_t   mode_q;
    ubr_baud_t   baud_q;
    logic [10:0] ratio_q;
    logic [7:0]  code_q;
    logic        rx_pend;
    logic        tx_pend;
    logic        sck_s1;
    logic        sck_s2;
    logic        sck_s3;
    logic [2:0]  pre_cnt;
    logic [3:0]  os_cnt;
    logic [10:0] etu_cnt;
    logic        sq_p;
    logic        sq_n;
    logic [15:0] div_count;
    logic        div_tick;

    // Returns {enable, pending} for one direction after a command write.
    function automatic logic [1:0] ubr_next_dir(
        input logic en,
        input logic pend,
        input logic en_cmd,
        input logic dis_cmd,
        input logic rst_cmd,
        input logic busy
    );
        logic e;
        logic p;
        e = en;
        p = pend;
        if (en_cmd)
        begin
            e = 1'b1;
            p = 1'b0;
        end
        else if (dis_cmd)
        begin
            p = en;
        end
        // A reset ends the character at once, so no wait is needed then.
        if (p && (rst_cmd || !busy))
        begin
            e = 1'b0;
            p = 1'b0;
        end
        ubr_next_dir = {e, p};
    endfunction

    wire wr_ctl   = wr_en && addr == OFS_CONTROL;
    wire wr_mode  = wr_en && addr == OFS_MODE;
    wire wr_baud  = wr_en && addr == OFS_BAUD;
    wire wr_ratio = wr_en && addr == OFS_RATIO;
    wire wr_code  = wr_en && addr == OFS_CODE;

    wire rx_dis_cmd = wr_ctl && wr_data[CTL_RX_DIS];
    wire tx_dis_cmd = wr_ctl && wr_data[CTL_TX_DIS];
    wire rx_en_cmd  = wr_ctl && wr_data[CTL_RX_EN] && !rx_dis_cmd;
    wire tx_en_cmd  = wr_ctl && wr_data[CTL_TX_EN] && !tx_dis_cmd;
    wire rx_rst_cmd = wr_ctl && wr_data[CTL_RX_RST];
    wire tx_rst_cmd = wr_ctl && wr_data[CTL_TX_RST];
    // The held character counts as busy so both drain before stopping.
    wire tx_draining = tx_busy || holding_full;

    wire [1:0] next_rx = ubr_next_dir(rx_enable, rx_pend, rx_en_cmd,
                                      rx_dis_cmd, rx_rst_cmd,
                                      rx_busy);
    wire [1:0] next_tx = ubr_next_dir(tx_enable, tx_pend, tx_en_cmd,
                                      tx_dis_cmd, tx_rst_cmd,
                                      tx_draining);

    wire [1:0] op      = mode_q.op_mode;
    wire [1:0] src_sel = mode_q.clock_source_select;
    wire sck_rise      = sck_s2 && !sck_s3;
    wire pre_tick      = pre_cnt == PRE_LAST;
    wire pin_direct    = op == OP_SYNC && src_sel == SRC_PIN;
    wire frac_en       = op == OP_ASYNC
                         && baud_q.fractional_part != 3'h0;
    wire is_async      = op != OP_SYNC && op != OP_CARD;
    wire [3:0] os_last = mode_q.over ? OS8_LAST : OS16_LAST;
    wire os_end        = div_tick && os_cnt >= os_last;
    wire etu_end       = div_tick && ratio_q != 11'h000
                         && etu_cnt >= ratio_q - 11'h001;
    wire [15:0] half   = {1'b0, baud_q.clock_divisor[15:1]};
    wire odd_master    = baud_q.clock_divisor[0]
                         && src_sel == SRC_MASTER;

    // Source 2 is reserved and yields no clock.
    wire src_tick = src_sel == SRC_MASTER  ? 1'b1 :
                    src_sel == SRC_DIVIDED ? pre_tick :
                    src_sel == SRC_PIN     ? sck_rise : 1'b0;

    ubr_frac_div #(
        .DIV_W    (16)
    ) u_div (
        .ref_clk  (ref_clk),
        .reset_n  (reset_n),
        .src_tick (src_tick),
        .frac_en  (frac_en),
        .divisor  (baud_q.clock_divisor),
        .frac     (baud_q.fractional_part),
        .div_tick (div_tick),
        .count    (div_count)
    );

    assign sample_tick = pin_direct ? sck_rise : div_tick;
    assign baud_tick   = pin_direct      ? sck_rise :
                         op == OP_SYNC   ? div_tick :
                         op == OP_CARD   ? etu_end  :
                         os_end;
    assign sck_out     = sq_p || sq_n;
    assign sck_oe      = (op == OP_SYNC && src_sel != SRC_PIN)
                         || (op == OP_CARD
                             && mode_q.clock_out_drive);

    wire [31:0] status_word = {10'h0,
                               ubr_adjust_factor(code_q[3:0]),
                               ubr_rate_factor(code_q[7:4]),
                               tx_pend, rx_pend, tx_enable, rx_enable};
    wire [31:0] rd_word =
        addr == OFS_MODE   ? {26'h0, mode_q} :
        addr == OFS_BAUD   ? {13'h0, baud_q} :
        addr == OFS_RATIO  ? {21'h0, ratio_q} :
        addr == OFS_CODE   ? {24'h000000, code_q} :
        addr == OFS_STATUS ? status_word : 32'h00000000;

    // Configuration accepts writes at any time, enabled or not.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            mode_q  <= MODE_RST;
            baud_q  <= BAUD_RST;
            ratio_q <= RATIO_RST;
            code_q  <= CODE_RST;
        end
        else
        begin
            if (wr_mode)
                mode_q <= wr_data[5:0];
            if (wr_baud)
                baud_q <= wr_data[18:0];
            if (wr_ratio)
                ratio_q <= wr_data[10:0];
            if (wr_code)
                code_q <= wr_data[7:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            rx_enable <= 1'b0;
            tx_enable <= 1'b0;
            rx_pend   <= 1'b0;
            tx_pend   <= 1'b0;
            rx_reset  <= 1'b0;
            tx_reset  <= 1'b0;
            rd_data   <= 32'h00000000;
        end
        else
        begin
            {rx_enable, rx_pend} <= next_rx;
            {tx_enable, tx_pend} <= next_tx;
            rx_reset <= rx_rst_cmd;
            tx_reset <= tx_rst_cmd;
            rd_data  <= rd_en ? rd_word : 32'h00000000;
        end
    end

    // The pin must run well below the master clock for edges to be seen.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
        end
        else
        begin
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            pre_cnt <= 3'h0;
            os_cnt  <= 4'h0;
            etu_cnt <= 11'h000;
        end
        else
        begin
            pre_cnt <= pre_cnt + 3'h1;
            if (!is_async || os_end)
                os_cnt <= 4'h0;
            else if (div_tick)
                os_cnt <= os_cnt + 4'h1;
            if (op != OP_CARD || etu_end)
                etu_cnt <= 11'h000;
            else if (div_tick)
                etu_cnt <= etu_cnt + 11'h001;
        end
    end

    // The falling-edge copy stretches the high phase by half a cycle so
    // an odd divisor above 1 on the master source in sync mode gives an even mark and space.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            sq_p <= 1'b0;
        else
            sq_p <= (op == OP_SYNC || op == OP_CARD)
                    && div_count < half;
    end

    always_ff @(negedge ref_clk)
    begin
        if (!reset_n)
            sq_n <= 1'b0;
        else
            sq_n <= sq_p && odd_master && op == OP_SYNC;
    end

    // Helper for the checks: cycles since the last divider tick, zeroed
    // whenever the mode or baud register is rewritten.
    logic [16:0] gap;
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || wr_mode || wr_baud)
            gap <= 17'h00000;
        else if (div_tick)
            gap <= 17'h00001;
        else if (gap != 17'h00000 && gap != 17'h1ffff)
            gap <= gap + 17'h00001;
    end

    wire [16:0] div_ext = {1'b0, baud_q.clock_divisor};
    wire        gap_ok  = div_tick && gap != 17'h00000
                          && src_sel == SRC_MASTER;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    frac_period_a: assert property (
        gap_ok && frac_en |-> gap == div_ext || gap == div_ext + 17'h00001)
        else $error("fractional period outside divisor range");
    plain_period_a: assert property (
        gap_ok && !frac_en |-> gap == div_ext)
        else $error("period differs from divisor without fraction");
    sync_divide_a: assert property (
        op == OP_SYNC && !pin_direct && div_tick |-> baud_tick && sample_tick)
        else $error("sync bit clock not the divider output");
    pin_direct_a: assert property (
        pin_direct |-> baud_tick == sck_rise)
        else $error("pin clock not passed straight through");
    stop_zero_a: assert property (
        baud_q.clock_divisor == 16'h0000 && !wr_baud |=> !div_tick)
        else $error("divider ticks with zero divisor");
    ratio_reset_a: assert property (
        $rose(reset_n) |-> ratio_q == RATIO_RST)
        else $error("ratio field wrong after reset");
    rx_start_a: assert property (
        $rose(rx_enable) |-> $past(rx_en_cmd))
        else $error("receiver enabled without command");
    tx_start_a: assert property (
        $rose(tx_enable) |-> $past(tx_en_cmd))
        else $error("transmitter enabled without command");
    rx_finish_a: assert property (
        rx_enable && rx_busy && !rx_rst_cmd |=> rx_enable)
        else $error("receiver stopped mid character");
    tx_finish_a: assert property (
        tx_enable && tx_draining && !tx_rst_cmd |=> tx_enable)
        else $error("transmitter stopped before draining");
    reset_cmd_a: assert property (
        tx_rst_cmd |=> tx_reset && !tx_pend
        ##1 tx_reset == $past(tx_rst_cmd))
        else $error("transmit reset pulse wrong");
    both_cmd_a: assert property (
        wr_ctl && wr_data[CTL_RX_EN] && wr_data[CTL_RX_DIS]
        |=> !$rose(rx_enable))
        else $error("enable won over disable");
    card_etu_a: assert property (
        op == OP_CARD && ratio_q < 11'h002
        |-> baud_tick == (div_tick && ratio_q != 11'h000))
        else $error("card bit time wrong for ratio zero or one");

    frac_seen_c: cover property (gap_ok && frac_en
                                 && gap == div_ext + 17'h00001);
    odd_duty_c:  cover property (sq_n && op == OP_SYNC);
    card_etu_c:  cover property (op == OP_CARD && etu_end);
    rx_wait_c:   cover property (rx_pend && rx_busy ##1 !rx_enable);
endmodule
`default_nettype wire

// [pkg/ubr_pkg.sv]
`default_nettype none
package ubr_pkg;
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_MODE    = 8'h04;
    localparam logic [7:0] OFS_BAUD    = 8'h08;
    localparam logic [7:0] OFS_RATIO   = 8'h0c;
    localparam logic [7:0] OFS_CODE    = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam int CTL_RX_RST = 2;
    localparam int CTL_TX_RST = 3;
    localparam int CTL_RX_EN  = 4;
    localparam int CTL_RX_DIS = 5;
    localparam int CTL_TX_EN  = 6;
    localparam int CTL_TX_DIS = 7;
    localparam logic [1:0] OP_ASYNC    = 2'h0;
    localparam logic [1:0] OP_SYNC     = 2'h1;
    localparam logic [1:0] OP_CARD     = 2'h2;
    localparam logic [1:0] SRC_MASTER  = 2'h0;
    localparam logic [1:0] SRC_DIVIDED = 2'h1;
    localparam logic [1:0] SRC_PIN     = 2'h3;
    localparam logic [2:0] PRE_LAST    = 3'h7;
    localparam logic [3:0] OS16_LAST   = 4'hf;
    localparam logic [3:0] OS8_LAST    = 4'h7;
    localparam logic [10:0] RATIO_RST  = 11'h174;
    localparam logic [7:0] CODE_RST    = 8'h11;

    typedef struct packed {
        logic       clock_out_drive;
        logic       over;
        logic [1:0] clock_source_select;
        logic [1:0] op_mode;
    } ubr_mode_t;

    typedef struct packed {
        logic [2:0]  fractional_part;
        logic [15:0] clock_divisor;
    } ubr_baud_t;

    localparam ubr_mode_t MODE_RST = 6'h00;
    localparam ubr_baud_t BAUD_RST = 19'h00000;

    function automatic logic [11:0] ubr_rate_factor(input logic [3:0] c);
        case (c)
            4'h0, 4'h1: ubr_rate_factor = 12'h174;
            4'h2:       ubr_rate_factor = 12'h22e;
            4'h3:       ubr_rate_factor = 12'h2e8;
            4'h4:       ubr_rate_factor = 12'h45c;
            4'h5:       ubr_rate_factor = 12'h5d0;
            4'h6:       ubr_rate_factor = 12'h744;
            4'h9:       ubr_rate_factor = 12'h200;
            4'ha:       ubr_rate_factor = 12'h300;
            4'hb:       ubr_rate_factor = 12'h400;
            4'hc:       ubr_rate_factor = 12'h600;
            4'hd:       ubr_rate_factor = 12'h800;
            default:    ubr_rate_factor = 12'h000;
        endcase
    endfunction

    function automatic logic [5:0] ubr_adjust_factor(input logic [3:0] c);
        case (c)
            4'h1:    ubr_adjust_factor = 6'h01;
            4'h2:    ubr_adjust_factor = 6'h02;
            4'h3:    ubr_adjust_factor = 6'h04;
            4'h4:    ubr_adjust_factor = 6'h08;
            4'h5:    ubr_adjust_factor = 6'h10;
            4'h6:    ubr_adjust_factor = 6'h20;
            4'h8:    ubr_adjust_factor = 6'h0c;
            4'h9:    ubr_adjust_factor = 6'h14;
            default: ubr_adjust_factor = 6'h00;
        endcase
    endfunction
endpackage
`default_nettype wire

// [core/ubr_frac_div.sv]
`timescale 1ns/10ps
`default_nettype none
module ubr_frac_div
    import ubr_pkg::*;
#(
    parameter int DIV_W = 16
)
(
    input  wire logic             ref_clk,
    input  wire logic             reset_n,
    input  wire logic             src_tick,
    input  wire logic             frac_en,
    input  wire logic [DIV_W-1:0] divisor,
    input  wire logic [2:0]       frac,
    output logic                  div_tick,
    output logic [DIV_W-1:0]      count
);
    logic [2:0]     acc;
    logic [3:0]     acc_sum;
    logic           stretch;
    logic [DIV_W:0] last;
    logic           at_end;

    // The carry out of the eighths accumulator lengthens one period by one.
    assign acc_sum  = {1'b0, acc} + {1'b0, frac};
    assign stretch  = frac_en && acc_sum[3];
    assign last     = {1'b0, divisor} + {{DIV_W{1'b0}}, stretch}
                      - {{DIV_W{1'b0}}, 1'b1};
    // Comparing with >= recovers at once when the divisor is lowered.
    assign at_end   = src_tick && (divisor != '0)
                      && ({1'b0, count} >= last);
    assign div_tick = at_end;

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || divisor == '0)
        begin
            count <= '0;
            acc   <= 3'h0;
        end
        else if (at_end)
        begin
            count <= '0;
            acc   <= frac_en ? acc_sum[2:0] : 3'h0;
        end
        else if (src_tick)
        begin
            count <= count + 1'b1;
        end
    end
endmodule
`default_nettype wire

// [sim/ubr_line_model.sv]
`timescale 1ns/10ps
`default_nettype none
module ubr_line_model
#(
    parameter int HALF_NS = 50
)
(
    input  wire logic run,
    output logic      sck_in
);
    // The pin clock stands low between bursts; a tenth of the master rate
    // keeps the pin well inside the synchroniser margin.
    initial
    begin
        sck_in = 1'b0;
        #3;
        forever
        begin
            wait (run === 1'b1);
            #(HALF_NS) sck_in = 1'b1;
            #(HALF_NS) sck_in = 1'b0;
        end
    end
endmodule
`default_nettype wire

// [sim/ubr_baud_ctrl_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ubr_baud_ctrl_tb_top
    import ubr_pkg::*;
;
    localparam logic [31:0] RXR = 32'h1 << CTL_RX_RST;
    localparam logic [31:0] TXR = 32'h1 << CTL_TX_RST;
    localparam logic [31:0] RXE = 32'h1 << CTL_RX_EN;
    localparam logic [31:0] RXD = 32'h1 << CTL_RX_DIS;
    localparam logic [31:0] TXE = 32'h1 << CTL_TX_EN;
    localparam logic [31:0] TXD = 32'h1 << CTL_TX_DIS;
    int rate_f [16] = '{372, 372, 558, 744, 1116, 1488, 1860, 0,
                        0, 512, 768, 1024, 1536, 2048, 0, 0};
    int adj_f [16] = '{0, 1, 2, 4, 8, 16, 32, 0, 12, 20, 0, 0, 0, 0, 0, 0};
    logic        ref_clk, reset_n, wr_en, rd_en, run;
    logic        rx_busy, tx_busy, holding_full, sck_in, sck_out, sck_oe;
    logic        sample_tick, baud_tick, rx_enable, tx_enable;
    logic        rx_reset, tx_reset;
    logic [7:0]  addr;
    logic [31:0] wr_data, rd_data, seen;
    int          errors, samples_checked, n;

    ubr_baud_ctrl i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe),
        .rx_busy(rx_busy), .tx_busy(tx_busy), .holding_full(holding_full),
        .sample_tick(sample_tick), .baud_tick(baud_tick),
        .rx_enable(rx_enable), .tx_enable(tx_enable),
        .rx_reset(rx_reset), .tx_reset(tx_reset));
    ubr_line_model i_line (.run(run), .sck_in(sck_in));

    always #5 ref_clk = ~ref_clk;

    task automatic print_verdict();
        if (errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge ref_clk);
        wr_en   <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    // Cycles between two baud ticks; the first two intervals after a change
    // are skipped since their phase is arbitrary.
    task automatic gap(output int p);
        for (int k = 0; k < 3; k++)
        begin
            p = 0;
            do
            begin
                @(negedge ref_clk);
                p++;
            end
            while (baud_tick !== 1'b1 && p < 4000);
        end
    endtask

    task automatic t_reset();
        rd(OFS_RATIO, seen);
        chk("ratio", seen, 32'h00000174);
        rd(OFS_CODE, seen);
        chk("code", seen, 32'h00000011);
        rd(8'h20, seen);
        chk("unmapped", seen, 32'h00000000);
        chk("rx_enable", rx_enable, 1'b0);
        chk("tx_enable", tx_enable, 1'b0);
    endtask

    task automatic t_codes();
        for (int i = 0; i < 16; i++)
        begin
            wr(OFS_CODE, {24'h0, i[3:0], i[3:0]});
            rd(OFS_STATUS, seen);
            chk("rate", seen[15:4], rate_f[i]);
            chk("adjust", seen[21:16], adj_f[i]);
        end
    endtask

    task automatic t_enable();
        wr(OFS_RATIO, 32'h00000005);
        rd(OFS_RATIO, seen);
        chk("ratio", seen, 32'h00000005);
        wr(OFS_CONTROL, RXE);
        chk("rx_enable", {rx_enable, tx_enable}, 2'h2);
        wr(OFS_CONTROL, TXE);
        chk("both", {rx_enable, tx_enable}, 2'h3);
        wr(OFS_CONTROL, RXE | RXD | TXE | TXD);
        chk("both off", {rx_enable, tx_enable}, 2'h0);
        wr(OFS_CONTROL, RXE | RXD);
        chk("rx_enable", rx_enable, 1'b0);
    endtask

    task automatic t_drain();
        wr(OFS_CONTROL, RXE | TXE);
        @(posedge ref_clk);
        rx_busy      <= 1'b1;
        holding_full <= 1'b1;
        wr(OFS_CONTROL, RXD | TXD);
        repeat (4) @(posedge ref_clk);
        #1 chk("both", {rx_enable, tx_enable}, 2'h3);
        @(posedge ref_clk);
        rx_busy      <= 1'b0;
        holding_full <= 1'b0;
        tx_busy      <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("rx tx", {rx_enable, tx_enable}, 2'h1);
        @(posedge ref_clk);
        tx_busy <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 chk("tx_enable", tx_enable, 1'b0);
    endtask

    task automatic t_swreset();
        wr(OFS_CONTROL, RXE);
        @(posedge ref_clk);
        rx_busy <= 1'b1;
        wr(OFS_CONTROL, RXD);
        chk("pending", rx_enable, 1'b1);
        wr(OFS_CONTROL, RXR | TXR);
        chk("resets", {rx_reset, tx_reset}, 2'h3);
        @(posedge ref_clk);
        #1 chk("resets", {rx_reset, tx_reset}, 2'h0);
        chk("rx_enable", rx_enable, 1'b0);
        @(posedge ref_clk);
        rx_busy <= 1'b0;
        rd(OFS_RATIO, seen);
        chk("ratio", seen, 32'h00000005);
    endtask

    task automatic t_async();
        wr(OFS_MODE, 32'h00000010);
        wr(OFS_BAUD, 32'h00000003);
        gap(n);
        chk("over8", n, 32'd24);
        n = 0;
        repeat (24) @(negedge ref_clk) n += int'(sample_tick);
        chk("samples", n, 32'd8);
        wr(OFS_BAUD, 32'h00040003);
        gap(n);
        chk("fraction", n, 32'd28);
        wr(OFS_MODE, 32'h00000013);
        gap(n);
        chk("other", n, 32'd24);
        wr(OFS_MODE, 32'h00000000);
        wr(OFS_BAUD, 32'h00000002);
        gap(n);
        chk("over16", n, 32'd32);
    endtask

    task automatic t_sync();
        int h;
        wr(OFS_MODE, 32'h00000001);
        wr(OFS_BAUD, 32'h00000005);
        gap(n);
        chk("sync", n, 32'd5);
        h = 0;
        repeat (10)
        begin
            @(posedge ref_clk);
            #2 h += int'(sck_out);
            @(negedge ref_clk);
            #2 h += int'(sck_out);
        end
        chk("duty", h, 32'd10);
        wr(OFS_MODE, 32'h00000005);
        wr(OFS_BAUD, 32'h00000002);
        gap(n);
        chk("divided", n, 32'd16);
        wr(OFS_MODE, 32'h00000001);
        wr(OFS_BAUD, 32'h00000001);
        gap(n);
        chk("bypass", n, 32'd1);
        wr(OFS_BAUD, 32'h00000000);
        h = 0;
        repeat (200) @(negedge ref_clk) h += int'(baud_tick);
        chk("stopped", h, 32'd0);
        wr(OFS_MODE, 32'h00000009);
        wr(OFS_BAUD, 32'h00000001);
        h = 0;
        repeat (50) @(negedge ref_clk) h += int'(baud_tick);
        chk("no source", h, 32'd0);
    endtask

    task automatic t_pin();
        wr(OFS_MODE, 32'h0000000d);
        wr(OFS_BAUD, 32'h00000007);
        run <= 1'b1;
        gap(n);
        chk("pin", n, 32'd10);
        run <= 1'b0;
    endtask

    task automatic t_card();
        wr(OFS_MODE, 32'h00000022);
        wr(OFS_BAUD, 32'h00000002);
        wr(OFS_RATIO, 32'h00000003);
        chk("sck_oe", sck_oe, 1'b1);
        gap(n);
        chk("card", n, 32'd6);
        n = 0;
        repeat (10) @(negedge ref_clk) n += int'(sck_out);
        chk("card clock", n, 32'd5);
    endtask

    initial
    begin
        #500000;
        errors++;
        print_verdict();
    end

    initial
    begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        {wr_en, rd_en, run, rx_busy, tx_busy, holding_full} = 6'h00;
        addr = 8'h00;
        wr_data = 32'h00000000;
        errors = 0;
        samples_checked = 0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        t_reset();
        t_codes();
        t_enable();
        t_drain();
        t_swreset();
        t_async();
        t_sync();
        t_pin();
        t_card();
        print_verdict();
    end
endmodule
`default_nettype wire
